// File: hdl/rmcr_pkg.sv
// constants for the regulator mode control register bank
package rmcr_pkg;
	localparam int unsigned NUM_CH = 7;
	localparam int unsigned NUM_LL = 3;
	localparam logic [7:0] ADDR_DC_LINE = 8'h1F;
	localparam logic [7:0] ADDR_AC_LINE = 8'h25;
	localparam logic [7:0] ADDR_IDLE_CFG = 8'h7A;
	localparam logic [7:0] ADDR_MPG_SEL = 8'h7C;
	localparam logic [7:0] ADDR_SS_DONE = 8'h8F;
	localparam logic [7:0] ADDR_FORCED = 8'hAD;
	localparam logic [2:0] RST_DC_LINE = 3'h3;
	localparam logic [2:0] RST_AC_LINE = 3'h3;
	localparam logic [2:0] RST_IDLE_CFG = 3'h0;
	localparam logic [2:0] RST_MPG_SEL = 3'h2;
	localparam logic [6:0] RST_FORCED = 7'h00;
	localparam logic [2:0] MPG_SEL_OFF = 3'h7;
	localparam logic [1:0] DROP_TIMER_OFF = 2'h3;
	localparam int unsigned SRC_FORCED_A = 3;
	localparam int unsigned DST_FORCED_A = 4;
	localparam int unsigned SRC_FORCED_B = 5;
	localparam int unsigned DST_FORCED_B = 6;
endpackage : rmcr_pkg

// File: hdl/rmcr_regs.sv
// mode control register bank for the seven step-down channels
// Notes on behaviour
// - Bits 6..0 of the forced-mode register force fixed-frequency PWM per channel when 1.
// - On the one-time image load, bit 3 is copied to bit 4 and bit 5 to bit 6.
// - After the load every forced-mode bit is written independently by the host.
// - The DC load-line register holds enables for channels 0..2, reset value 011.
// - The AC load-line register holds enables for channels 0..2, reset value 011.
// - The rail selector picks channel 0..6 for the memory power-good monitor, reset 010.
// - Selector code 111 turns the monitor off and holds power-good low.
// - The read-only status shows per channel 1 once soft-start is done and the channel is enabled, else 0.
// - The idle-configuration register holds idle enables for channels 0..2, reset 0.
// - With expansion units, automatic mode needs forced bit 0 and idle bit 1.
// - Without expansion units the idle bit is ignored and the forced bit decides.
// - A phase-drop timer of 11 forces PWM regardless of the other bits.
// - With shedding enabled automatic mode needs forced bit 0, and idle bit 1 only with expansion units.
// - A 1-to-0 idle change takes effect only after the rail is power cycled.
// - The phase-drop timer is bits 1..0 of the phase configuration of each of channels 0..2.
`timescale 1ns/1ps
module rmcr_regs #(
	parameter int unsigned NUM_CH = rmcr_pkg::NUM_CH,
	parameter int unsigned NUM_LL = rmcr_pkg::NUM_LL
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	input wire logic image_load,
	input wire logic [6:0] image_forced,
	input wire logic [NUM_CH-1:0] soft_start_done,
	input wire logic [NUM_CH-1:0] channel_enabled,
	input wire logic [NUM_CH-1:0] rail_power_good,
	input wire logic [NUM_LL-1:0] expansion_phase_unit,
	input wire logic [2*NUM_LL-1:0] phase_drop_timer,
	input wire logic [NUM_LL-1:0] rail_power_cycle,
	output logic [NUM_CH-1:0] forced_fixed_frequency_mode,
	output logic [NUM_LL-1:0] channel_dc_line_bit,
	output logic [NUM_LL-1:0] channel_ac_line_bit,
	output logic memory_power_good
);
	logic [6:0] forced_q;
	logic [2:0] dc_line_q;
	logic [2:0] ac_line_q;
	logic [2:0] idle_q;
	logic [2:0] idle_eff_q;
	logic [2:0] mpg_sel_q;
	logic [6:0] image_val;
	logic [6:0] ss_status;
	logic [NUM_CH-1:0] mode_d;
	logic [7:0] rdata_d;
	logic mpg_d;
	wire wr_forced = reg_wr && (reg_addr == rmcr_pkg::ADDR_FORCED);
	wire wr_dc = reg_wr && (reg_addr == rmcr_pkg::ADDR_DC_LINE);
	wire wr_ac = reg_wr && (reg_addr == rmcr_pkg::ADDR_AC_LINE);
	wire wr_idle = reg_wr && (reg_addr == rmcr_pkg::ADDR_IDLE_CFG);
	wire wr_sel = reg_wr && (reg_addr == rmcr_pkg::ADDR_MPG_SEL);

	// replicate the two shared bits from the image
	always_comb begin
		image_val = image_forced;
		image_val[rmcr_pkg::DST_FORCED_A] = image_forced[rmcr_pkg::SRC_FORCED_A];
		image_val[rmcr_pkg::DST_FORCED_B] = image_forced[rmcr_pkg::SRC_FORCED_B];
	end

	// done only while the channel is enabled
	assign ss_status = soft_start_done & channel_enabled;

	// image load wins over a host write in the same cycle
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			forced_q <= rmcr_pkg::RST_FORCED;
		end else if (image_load) begin
			forced_q <= image_val;
		end else if (wr_forced) begin
			forced_q <= reg_wdata[6:0];
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			dc_line_q <= rmcr_pkg::RST_DC_LINE;
			ac_line_q <= rmcr_pkg::RST_AC_LINE;
			idle_q <= rmcr_pkg::RST_IDLE_CFG;
			mpg_sel_q <= rmcr_pkg::RST_MPG_SEL;
		end else begin
			if (wr_dc) dc_line_q <= reg_wdata[2:0];
			if (wr_ac) ac_line_q <= reg_wdata[2:0];
			if (wr_idle) idle_q <= reg_wdata[2:0];
			if (wr_sel) mpg_sel_q <= reg_wdata[2:0];
		end
	end

	// idle enable in force: rises at once, falls only on a power cycle
	genvar gi;
	generate
		for (gi = 0; gi < NUM_LL; gi++) begin : g_idle
			always_ff @(posedge clk_sys or negedge rst_n) begin
				if (!rst_n) begin
					idle_eff_q[gi] <= rmcr_pkg::RST_IDLE_CFG[gi];
				end else if (idle_q[gi] || rail_power_cycle[gi]) begin
					idle_eff_q[gi] <= idle_q[gi];
				end
			end
		end
	endgenerate

	// per-channel mode decision
	generate
		for (gi = 0; gi < NUM_CH; gi++) begin : g_mode
			if (gi < NUM_LL) begin : g_ps
				wire shed_off = phase_drop_timer[2*gi +: 2] == rmcr_pkg::DROP_TIMER_OFF;
				wire need_idle = expansion_phase_unit[gi];
				assign mode_d[gi] = forced_q[gi] || shed_off
					|| (need_idle && !idle_eff_q[gi]);
			end else begin : g_plain
				assign mode_d[gi] = forced_q[gi];
			end
		end
	endgenerate

	assign mpg_d = (mpg_sel_q != rmcr_pkg::MPG_SEL_OFF) && rail_power_good[mpg_sel_q];

	always_comb begin
		rdata_d = 8'h00;
		case (reg_addr)
			rmcr_pkg::ADDR_FORCED: rdata_d = {1'b0, forced_q};
			rmcr_pkg::ADDR_DC_LINE: rdata_d = {5'h00, dc_line_q};
			rmcr_pkg::ADDR_AC_LINE: rdata_d = {5'h00, ac_line_q};
			rmcr_pkg::ADDR_IDLE_CFG: rdata_d = {5'h00, idle_q};
			rmcr_pkg::ADDR_MPG_SEL: rdata_d = {5'h00, mpg_sel_q};
			rmcr_pkg::ADDR_SS_DONE: rdata_d = {1'b0, ss_status};
			default: rdata_d = 8'h00;
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 8'h00;
			forced_fixed_frequency_mode <= '1;
			channel_dc_line_bit <= rmcr_pkg::RST_DC_LINE;
			channel_ac_line_bit <= rmcr_pkg::RST_AC_LINE;
			memory_power_good <= 1'b0;
		end else begin
			if (reg_rd) reg_rdata <= rdata_d;
			forced_fixed_frequency_mode <= mode_d;
			channel_dc_line_bit <= dc_line_q;
			channel_ac_line_bit <= ac_line_q;
			memory_power_good <= mpg_d;
		end
	end

	chk_image_copy_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		image_load |=> forced_q[4] == $past(image_forced[3]))
		else $error("bit 4 not copied from bit 3");
	chk_image_copy_b: assert property (@(posedge clk_sys) disable iff (!rst_n)
		image_load |=> forced_q[6] == $past(image_forced[5]))
		else $error("bit 6 not copied from bit 5");
	chk_forced_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
		wr_forced && !image_load |=> forced_q == $past(reg_wdata[6:0]))
		else $error("forced-mode write not independent");
	chk_dc_line_out: assert property (@(posedge clk_sys) disable iff (!rst_n)
		wr_dc |=> ##1 channel_dc_line_bit == $past(reg_wdata[2:0], 2))
		else $error("dc line output wrong");
	chk_ac_line_out: assert property (@(posedge clk_sys) disable iff (!rst_n)
		wr_ac |=> ##1 channel_ac_line_bit == $past(reg_wdata[2:0], 2))
		else $error("ac line output wrong");
	chk_monitor_off: assert property (@(posedge clk_sys) disable iff (!rst_n)
		mpg_sel_q == rmcr_pkg::MPG_SEL_OFF |=> !memory_power_good)
		else $error("power good not low when off");
	chk_monitor_sel: assert property (@(posedge clk_sys) disable iff (!rst_n)
		mpg_sel_q != rmcr_pkg::MPG_SEL_OFF |=> memory_power_good == $past(rail_power_good[mpg_sel_q]))
		else $error("power good follows wrong rail");
	chk_status_read: assert property (@(posedge clk_sys) disable iff (!rst_n)
		reg_rd && reg_addr == rmcr_pkg::ADDR_SS_DONE
		|=> reg_rdata == {1'b0, $past(soft_start_done & channel_enabled)})
		else $error("soft-start status read wrong");
	chk_shed_off: assert property (@(posedge clk_sys) disable iff (!rst_n)
		phase_drop_timer[1:0] == rmcr_pkg::DROP_TIMER_OFF |=> forced_fixed_frequency_mode[0])
		else $error("shedding off did not force pwm");
	chk_auto_mode: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!forced_q[0] && phase_drop_timer[1:0] != rmcr_pkg::DROP_TIMER_OFF
		&& (!expansion_phase_unit[0] || idle_eff_q[0]) |=> !forced_fixed_frequency_mode[0])
		else $error("automatic mode not selected");
	chk_idle_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
		idle_eff_q[0] && !idle_q[0] && !rail_power_cycle[0] |=> idle_eff_q[0])
		else $error("idle dropped without power cycle");
	chk_rsvd_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
		reg_rd && reg_addr == rmcr_pkg::ADDR_IDLE_CFG |=> reg_rdata[7:3] == 5'h00)
		else $error("reserved bits not zero");

	// read of a given register, answer one cycle later
	sequence s_rd_dc;
		reg_rd && reg_addr == rmcr_pkg::ADDR_DC_LINE;
	endsequence
	sequence s_rd_ac;
		reg_rd && reg_addr == rmcr_pkg::ADDR_AC_LINE;
	endsequence
	sequence s_rd_sel;
		reg_rd && reg_addr == rmcr_pkg::ADDR_MPG_SEL;
	endsequence
	sequence s_rd_forced;
		reg_rd && reg_addr == rmcr_pkg::ADDR_FORCED;
	endsequence
	// write then the register copy one edge later
	sequence s_wr_idle;
		wr_idle ##1 1'b1;
	endsequence
	sequence s_wr_sel;
		wr_sel ##1 1'b1;
	endsequence

	chk_dc_readback: assert property (@(posedge clk_sys) disable iff (!rst_n)
		s_rd_dc |=> reg_rdata == {5'h00, $past(dc_line_q)})
		else $error("dc line read wrong");
	chk_ac_readback: assert property (@(posedge clk_sys) disable iff (!rst_n)
		s_rd_ac |=> reg_rdata == {5'h00, $past(ac_line_q)})
		else $error("ac line read wrong");
	chk_sel_readback: assert property (@(posedge clk_sys) disable iff (!rst_n)
		s_rd_sel |=> reg_rdata == {5'h00, $past(mpg_sel_q)})
		else $error("rail select read wrong");
	chk_forced_readback: assert property (@(posedge clk_sys) disable iff (!rst_n)
		s_rd_forced |=> reg_rdata == {1'b0, $past(forced_q)})
		else $error("forced-mode read wrong");
	chk_idle_store: assert property (@(posedge clk_sys) disable iff (!rst_n)
		s_wr_idle |-> idle_q == $past(reg_wdata[2:0]))
		else $error("idle config write wrong");
	chk_sel_store: assert property (@(posedge clk_sys) disable iff (!rst_n)
		s_wr_sel |-> mpg_sel_q == $past(reg_wdata[2:0]))
		else $error("rail select write wrong");
	chk_image_wins: assert property (@(posedge clk_sys) disable iff (!rst_n)
		image_load && wr_forced |=> forced_q[3:0] == $past(image_forced[3:0]))
		else $error("image load lost to host write");
	chk_unmapped_read: assert property (@(posedge clk_sys) disable iff (!rst_n)
		reg_rd && reg_addr != rmcr_pkg::ADDR_FORCED
		&& reg_addr != rmcr_pkg::ADDR_DC_LINE && reg_addr != rmcr_pkg::ADDR_AC_LINE
		&& reg_addr != rmcr_pkg::ADDR_IDLE_CFG && reg_addr != rmcr_pkg::ADDR_MPG_SEL
		&& reg_addr != rmcr_pkg::ADDR_SS_DONE |=> reg_rdata == 8'h00)
		else $error("unmapped address not zero");
	chk_rdata_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!reg_rd |=> $stable(reg_rdata))
		else $error("read data moved without a read");
	chk_dc_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!wr_dc |=> $stable(dc_line_q))
		else $error("dc line changed without write");
	chk_ac_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!wr_ac |=> $stable(ac_line_q))
		else $error("ac line changed without write");
	chk_forced_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!wr_forced && !image_load |=> $stable(forced_q))
		else $error("forced bits changed without write");
	chk_idle_rise: assert property (@(posedge clk_sys) disable iff (!rst_n)
		idle_q[0] |=> idle_eff_q[0])
		else $error("idle enable not taken at once");

	// per-channel mode checks
	generate
		for (gi = 0; gi < NUM_CH; gi++) begin : g_chk
			if (gi < NUM_LL) begin : g_chk_ps
				chk_ch_shed_off: assert property (@(posedge clk_sys) disable iff (!rst_n)
					phase_drop_timer[2*gi +: 2] == rmcr_pkg::DROP_TIMER_OFF
					|=> forced_fixed_frequency_mode[gi])
					else $error("shedding off did not force pwm");
				chk_ch_forced: assert property (@(posedge clk_sys) disable iff (!rst_n)
					forced_q[gi] |=> forced_fixed_frequency_mode[gi])
					else $error("forced bit did not force pwm");
				chk_ch_no_idle: assert property (@(posedge clk_sys) disable iff (!rst_n)
					expansion_phase_unit[gi] && !idle_eff_q[gi]
					|=> forced_fixed_frequency_mode[gi])
					else $error("idle disabled but automatic mode");
				chk_ch_auto: assert property (@(posedge clk_sys) disable iff (!rst_n)
					!forced_q[gi] && phase_drop_timer[2*gi +: 2] != rmcr_pkg::DROP_TIMER_OFF
					&& (!expansion_phase_unit[gi] || idle_eff_q[gi])
					|=> !forced_fixed_frequency_mode[gi])
					else $error("automatic mode not selected");
			end else begin : g_chk_plain
				chk_ch_plain: assert property (@(posedge clk_sys) disable iff (!rst_n)
					1'b1 |=> forced_fixed_frequency_mode[gi] == $past(forced_q[gi]))
					else $error("plain channel mode wrong");
			end
		end
	endgenerate
endmodule : rmcr_regs

// File: tb/rmcr_host.sv
// host model driving register strobes and rail power cycles
`timescale 1ns/1ps
module rmcr_host (
	input wire logic clk_sys,
	output logic reg_wr,
	output logic reg_rd,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	output logic [2:0] rail_power_cycle
);
	initial begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		rail_power_cycle = 3'h0;
	end
	// voltage id link taken as already off before any idle write
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_sys);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge clk_sys);
		reg_wr = 1'b0;
		reg_wdata = ~d;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk_sys);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge clk_sys);
		reg_rd = 1'b0;
		@(negedge clk_sys);
		d = reg_rdata;
	endtask : rd
	// power cycle of rails 0..2 after an idle bit drops
	task automatic cyc();
		@(negedge clk_sys);
		rail_power_cycle = 3'h7;
		@(negedge clk_sys);
		rail_power_cycle = 3'h0;
	endtask : cyc
endmodule : rmcr_host

// File: tb/tb_rmcr_regs.sv
// self-checking bench for the mode control register bank
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin err_total++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module tb_rmcr_regs;
	logic clk_sys = 1'b0, rst_n = 1'b0, image_load = 1'b0;
	logic reg_wr, reg_rd, mpg;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
	logic [6:0] image_forced = 7'h00, ssd = 7'h5A, cen = 7'h3C, rpg = 7'h55, mode;
	logic [2:0] epu = 3'h0, pcyc, dcl, acl;
	logic [5:0] pdt = 6'h00;
	int err_total = 0, compares = 0, cycles = 0;
	always #12.5 clk_sys = ~clk_sys;
	always @(posedge clk_sys) if (++cycles == 20000) begin err_total++; tally_and_finish(); end
	rmcr_regs rmcr_regs_inst (.clk_sys(clk_sys), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.image_load(image_load), .image_forced(image_forced), .soft_start_done(ssd),
		.channel_enabled(cen), .rail_power_good(rpg), .expansion_phase_unit(epu),
		.phase_drop_timer(pdt), .rail_power_cycle(pcyc), .forced_fixed_frequency_mode(mode),
		.channel_dc_line_bit(dcl), .channel_ac_line_bit(acl), .memory_power_good(mpg));
	rmcr_host rmcr_host_inst (.clk_sys(clk_sys), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.rail_power_cycle(pcyc));
	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		rmcr_host_inst.rd(a, d);
		`CHK(d, e)
	endtask : rchk
	task automatic settle();
		repeat (3) @(negedge clk_sys);
	endtask : settle
	task automatic t_defaults();
		rchk(rmcr_pkg::ADDR_DC_LINE, 8'h03);
		rchk(rmcr_pkg::ADDR_AC_LINE, 8'h03);
		rchk(rmcr_pkg::ADDR_IDLE_CFG, 8'h00);
		rchk(rmcr_pkg::ADDR_MPG_SEL, 8'h02);
		rchk(8'h40, 8'h00);
		rmcr_host_inst.wr(rmcr_pkg::ADDR_SS_DONE, 8'hFF);
		rchk(rmcr_pkg::ADDR_SS_DONE, 8'h18);
	endtask : t_defaults
	task automatic t_image();
		@(negedge clk_sys);
		image_forced = 7'h28;
		image_load = 1'b1;
		@(negedge clk_sys);
		image_load = 1'b0;
		rchk(rmcr_pkg::ADDR_FORCED, 8'h78);
		rmcr_host_inst.wr(rmcr_pkg::ADDR_FORCED, 8'h90);
		rchk(rmcr_pkg::ADDR_FORCED, 8'h10);
		rmcr_host_inst.wr(rmcr_pkg::ADDR_DC_LINE, 8'hFC);
		rmcr_host_inst.wr(rmcr_pkg::ADDR_AC_LINE, 8'hFA);
		rchk(rmcr_pkg::ADDR_DC_LINE, 8'h04);
		`CHK({dcl, acl}, 6'h22)
	endtask : t_image
	task automatic t_modes();
		logic f, e;
		for (int i = 0; i < 32; i++) begin
			f = i[0];
			e = (i[4:3] == 2'h3) | f | (i[2] & ~i[1]);
			epu = {3{i[2]}};
			pdt = {3{i[4:3]}};
			rmcr_host_inst.wr(rmcr_pkg::ADDR_IDLE_CFG, i[1] ? 8'h07 : 8'h00);
			rmcr_host_inst.cyc();
			rmcr_host_inst.wr(rmcr_pkg::ADDR_FORCED, f ? 8'h7F : 8'h00);
			settle();
			`CHK(mode, {{4{f}}, {3{e}}})
		end
		pdt = 6'h00;
		epu = 3'h7;
		rmcr_host_inst.wr(rmcr_pkg::ADDR_FORCED, 8'h00);
		rmcr_host_inst.wr(rmcr_pkg::ADDR_IDLE_CFG, 8'h07);
		settle();
		`CHK(mode, 7'h00)
		rmcr_host_inst.wr(rmcr_pkg::ADDR_IDLE_CFG, 8'h00);
		settle();
		`CHK(mode[2:0], 3'h0)
		rmcr_host_inst.cyc();
		settle();
		`CHK(mode[2:0], 3'h7)
	endtask : t_modes
	task automatic t_monitor();
		for (int s = 0; s < 8; s++) begin
			rmcr_host_inst.wr(rmcr_pkg::ADDR_MPG_SEL, 8'hF8 | s[7:0]);
			rpg = s[0] ? 7'h55 : 7'h2A;
			settle();
			`CHK(mpg, (s == 7) ? 1'b0 : rpg[s])
		end
		rchk(rmcr_pkg::ADDR_MPG_SEL, 8'h07);
	endtask : t_monitor
	task automatic tally_and_finish();
		$display("compares=%0d err_total=%0d", compares, err_total);
		if (err_total == 0 && compares > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : tally_and_finish
	initial begin
		repeat (12) @(negedge clk_sys);
		rst_n = 1'b1;
		t_defaults();
		t_image();
		t_modes();
		t_monitor();
		tally_and_finish();
	end
endmodule : tb_rmcr_regs
